/* File: rtl/interrupt_edge_and_enable_regs.sv */
// Edge polarity, enable and request flag registers of the interrupt controller.
`timescale 1ns/1ps
`include "intc_defines.svh"

// Overview of operation
// RL1: Edge register top three bits read one, fixed.
// RL2: Bit 4 sets pin 4 and trigger edge.
// RL3: Bit 3 sets pin 3 and timer F edge.
// RL4: Bit 2 sets pin 2 edge only.
// RL5: Bit 1 sets pin 1 and timer C edge.
// RL6: Bit 0 sets pin 0 edge only.
// RL7: First enable bit 7 gates timer A.
// RL8: First enable bit 6 is plain storage.
// RL9: First enable bit 5 gates wakeup group.
// RL10: First enable bits 4..0 gate external pins.
// RL11: Second enable bit 7 gates direct transfer.
// RL12: Second enable bit 6 gates conversion end.
// RL13: Second enable bit 5 is plain storage.
// RL14: Second enable bit 4 gates timer G.
// RL15: Second enable bit 3 gates timer FH.
// RL16: Second enable bit 2 gates timer FL.
// RL17: Second enable bit 1 gates timer C.
// RL18: Second enable bit 0 gates event counter.
// RL19: Global mask blocks acceptance, flags still set.
// RL20: Acceptance keeps flags; software writes zero.
// RL21: Pending needs flag or wakeup request, enable and clear mask.
module interrupt_edge_and_enable_regs (
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     ce_in,
   input  wire logic [15:0]              addr_in,
   input  wire logic [7:0]               wdata_in,
   input  wire logic                     wr_in,
   input  wire logic                     rd_in,
   output logic      [7:0]               rdata_out,
   input  wire intc_pkg::pins_s          pins_in,
   input  wire intc_pkg::source_events_s events_in,
   input  wire logic                     wakeup_request_in,
   input  wire logic                     global_mask_in,
   output intc_pkg::edge_pulses_s        edge_pulses_out,
   output logic      [7:0]               pending_first_out,
   output logic      [7:0]               pending_second_out,
   output logic                          irq_request_out
);
   import intc_pkg::*;

   logic [4:0]   edge_polarity_reg;
   logic [7:0]   enable_first_reg;
   logic [7:0]   enable_second_reg;
   logic [7:0]   flags_first_reg;
   logic [7:0]   flags_second_reg;
   logic [7:0]   pin_prev_reg;
   logic [7:0]   rdata_reg;
   edge_pulses_s pulses_reg;
   logic [7:0]   pend_first_reg;
   logic [7:0]   pend_second_reg;
   logic         request_reg;

   wire  [7:0]   pin_now;
   wire  [7:0]   lane_pol;
   wire  [7:0]   lane_hit;
   wire          wr_edge;
   wire          wr_en1;
   wire          wr_en2;
   wire          wr_flag1;
   wire          wr_flag2;
   wire  [7:0]   edge_read;
   wire  [7:0]   flags_first_read;
   wire  [7:0]   flags_first_set;
   wire  [7:0]   flags_first_clr;
   wire  [7:0]   flags_first_next;
   wire  [7:0]   flags_second_set;
   wire  [7:0]   flags_second_clr;
   wire  [7:0]   flags_second_spare;
   wire  [7:0]   flags_second_next;
   wire  [7:0]   mask_gate;
   wire  [7:0]   pend_first_next;
   wire  [7:0]   pend_second_next;
   wire          request_next;
   wire  [7:0]   rdata_next;
   edge_pulses_s pulses_next;

   assign wr_edge  = wr_in && (addr_in == `ADDR_EDGE_POLARITY);
   assign wr_en1   = wr_in && (addr_in == `ADDR_ENABLE_FIRST);
   assign wr_en2   = wr_in && (addr_in == `ADDR_ENABLE_SECOND);
   assign wr_flag1 = wr_in && (addr_in == `ADDR_FLAGS_FIRST);
   assign wr_flag2 = wr_in && (addr_in == `ADDR_FLAGS_SECOND);

   // RL1: fixed ones read
   assign edge_read = {`EDGE_FIXED_ONES, edge_polarity_reg};

   // The three event pins share a polarity bit with an external pin, so each
   // lane picks its own copy of the selector.
   assign pin_now = pins_in;
   // RL2: pin 4 shares
   // RL3: pin 3 shares
   // RL5: pin 1 shares
   assign lane_pol = {edge_polarity_reg[`POL_PIN1],
                      edge_polarity_reg[`POL_PIN3],
                      edge_polarity_reg[`POL_PIN4],
                      edge_polarity_reg};

   // RL4: per lane edge
   // RL6: per lane edge
   genvar lane;
   generate
      for (lane = 0; lane < 8; lane = lane + 1) begin : g_edge
         assign lane_hit[lane] = lane_pol[lane] ?
                                 (pin_now[lane] & ~pin_prev_reg[lane]) :
                                 (~pin_now[lane] & pin_prev_reg[lane]);
      end
   endgenerate

   assign pulses_next = {lane_hit[`LANE_TIMER_C],
                         lane_hit[`LANE_TIMER_F],
                         lane_hit[`LANE_TRIGGER]};

   // RL19: flags set regardless
   assign flags_first_set = {events_in.timer_a_overflow, 2'b00, lane_hit[4:0]};
   // RL20: only software clears
   assign flags_first_clr  = wr_flag1 ? (~wdata_in & flags_first_reg) : `BYTE_ZERO;
   // A set in the same cycle as a clearing write wins, so no event is lost.
   assign flags_first_next = ((flags_first_reg & ~flags_first_clr) | flags_first_set)
                             & ~`FLAGS_FIRST_FIXED;
   assign flags_first_read = flags_first_reg | `FLAGS_FIRST_FIXED;

   assign flags_second_set = {events_in.direct_transfer, events_in.conversion_end, 1'b0,
                              events_in.timer_g, events_in.timer_f_high,
                              events_in.timer_f_low, events_in.timer_c,
                              events_in.event_counter};
   assign flags_second_clr = wr_flag2 ? (~wdata_in & flags_second_reg) : `BYTE_ZERO;
   assign flags_second_spare = (wr_flag2 ? wdata_in : flags_second_reg)
                               & `FLAGS_SECOND_SPARE;
   assign flags_second_next = (((flags_second_reg & ~flags_second_clr) | flags_second_set)
                               & ~`FLAGS_SECOND_SPARE) | flags_second_spare;

   // RL19: mask blocks requests
   assign mask_gate = global_mask_in ? `BYTE_ZERO : ~`BYTE_ZERO;
   // RL7: timer A gate
   // RL9: wakeup group gate
   // RL10: external pin gates
   // RL21: flag and enable
   assign pend_first_next = {flags_first_reg[`BIT_TIMER_A], 1'b0, wakeup_request_in,
                             flags_first_reg[4:0]}
                            & enable_first_reg & `PEND_FIRST_MASK & mask_gate;
   // RL11: direct transfer gate
   // RL12: conversion end gate
   // RL14: timer G gate
   // RL15: timer FH gate
   // RL16: timer FL gate
   // RL17: timer C gate
   // RL18: event counter gate
   assign pend_second_next = flags_second_reg & enable_second_reg
                             & `PEND_SECOND_MASK & mask_gate;
   assign request_next = (|pend_first_next) | (|pend_second_next);

   assign rdata_next = !rd_in                              ? `RDATA_IDLE :
                       (addr_in == `ADDR_EDGE_POLARITY)    ? edge_read :
                       (addr_in == `ADDR_ENABLE_FIRST)     ? enable_first_reg :
                       (addr_in == `ADDR_ENABLE_SECOND)    ? enable_second_reg :
                       (addr_in == `ADDR_FLAGS_FIRST)      ? flags_first_read :
                       (addr_in == `ADDR_FLAGS_SECOND)     ? flags_second_reg :
                                                             `RDATA_IDLE;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         edge_polarity_reg <= `EDGE_POL_RESET;
         enable_first_reg  <= `ENABLE_RESET;
         enable_second_reg <= `ENABLE_RESET;
      end else if (ce_in) begin
         // RL1: only low bits stored
         if (wr_edge) begin
            edge_polarity_reg <= wdata_in[4:0];
         end
         // RL8: spare bit stored
         if (wr_en1) begin
            enable_first_reg <= wdata_in;
         end
         // RL13: spare bit stored
         if (wr_en2) begin
            enable_second_reg <= wdata_in;
         end
      end
   end

   // Pins idle high after reset, so a pin held low through reset is seen
   // as a falling edge at release while its polarity bit selects falling.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_prev_reg     <= `PIN_IDLE;
         flags_first_reg  <= `FLAGS_RESET;
         flags_second_reg <= `FLAGS_RESET;
      end else if (ce_in) begin
         pin_prev_reg     <= pin_now;
         flags_first_reg  <= flags_first_next;
         flags_second_reg <= flags_second_next;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_reg       <= `RDATA_IDLE;
         pulses_reg      <= '0;
         pend_first_reg  <= `BYTE_ZERO;
         pend_second_reg <= `BYTE_ZERO;
         request_reg     <= 1'b0;
      end else if (ce_in) begin
         rdata_reg       <= rdata_next;
         pulses_reg      <= pulses_next;
         pend_first_reg  <= pend_first_next;
         pend_second_reg <= pend_second_next;
         request_reg     <= request_next;
      end
   end

   assign rdata_out          = rdata_reg;
   assign edge_pulses_out    = pulses_reg;
   assign pending_first_out  = pend_first_reg;
   assign pending_second_out = pend_second_reg;
   assign irq_request_out    = request_reg;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   property p_edge_fixed_read;
      ce_in && rd_in && (addr_in == `ADDR_EDGE_POLARITY) |=> (rdata_out[7:5] == 3'b111);
   endproperty
   a_edge_fixed_read: assert property (p_edge_fixed_read) // RL1
      else $error("Edge register upper bits did not read as one.");

   property p_trigger_falling;
      ce_in && !edge_polarity_reg[`POL_PIN4] && pin_prev_reg[`LANE_TRIGGER]
         && !pins_in.conversion_trigger_pin
      |=> edge_pulses_out.conversion_trigger;
   endproperty
   a_trigger_falling: assert property (p_trigger_falling) // RL2
      else $error("Falling trigger edge was not reported.");

   property p_timer_f_rising;
      ce_in && edge_polarity_reg[`POL_PIN3] && !pin_prev_reg[`LANE_TIMER_F]
         && pins_in.timer_f_event_input
      |=> edge_pulses_out.timer_f_event && flags_first_reg[`POL_PIN3] == $past(lane_hit[3]) |
          flags_first_reg[`POL_PIN3];
   endproperty
   a_timer_f_rising: assert property (p_timer_f_rising) // RL3
      else $error("Rising timer F edge was not reported.");

   property p_pin2_flag;
      ce_in && (edge_polarity_reg[`POL_PIN2] ? (pin_now[2] && !pin_prev_reg[2])
                                             : (!pin_now[2] && pin_prev_reg[2]))
      |=> flags_first_reg[`POL_PIN2];
   endproperty
   a_pin2_flag: assert property (p_pin2_flag) // RL4
      else $error("Pin 2 edge did not set its flag.");

   property p_timer_c_no_wrong_edge;
      ce_in && !edge_polarity_reg[`POL_PIN1] && !pin_prev_reg[`LANE_TIMER_C]
         && pins_in.timer_c_event_input
      |=> !edge_pulses_out.timer_c_event;
   endproperty
   a_timer_c_no_wrong_edge: assert property (p_timer_c_no_wrong_edge) // RL5
      else $error("Timer C pulse on the unselected edge.");

   property p_pin0_rising;
      ce_in && edge_polarity_reg[`POL_PIN0] && !pin_prev_reg[0] && pin_now[0]
      |=> flags_first_reg[0];
   endproperty
   a_pin0_rising: assert property (p_pin0_rising) // RL6
      else $error("Pin 0 rising edge did not set its flag.");

   property p_spare_storage;
      ce_in && wr_en1 |=> enable_first_reg[`BIT_SPARE_FIRST] == $past(wdata_in[6]);
   endproperty
   a_spare_storage: assert property (p_spare_storage) // RL8
      else $error("Spare enable bit did not store the written value.");

   property p_mask_blocks;
      ce_in && global_mask_in |=> !irq_request_out && pending_first_out == 8'h00;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) // RL19
      else $error("Request shown while the global mask was set.");

   property p_flag_kept;
      ce_in && flags_second_reg[`BIT_TIMER_G] && !wr_flag2 |=> flags_second_reg[`BIT_TIMER_G];
   endproperty
   a_flag_kept: assert property (p_flag_kept) // RL20
      else $error("Timer G flag cleared without a software write.");

   property p_pending_cause;
      ce_in && !global_mask_in && flags_second_reg[`BIT_CONV_END]
         && enable_second_reg[`BIT_CONV_END]
      |=> pending_second_out[`BIT_CONV_END] && irq_request_out;
   endproperty
   a_pending_cause: assert property (p_pending_cause) // RL21
      else $error("Enabled conversion end flag gave no request.");

   property p_disabled_quiet;
      ce_in && !enable_first_reg[`BIT_TIMER_A] |=> !pending_first_out[`BIT_TIMER_A];
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) // RL7
      else $error("Disabled timer A showed a pending request.");

   property p_pin4_falling;
      ce_in && !edge_polarity_reg[`POL_PIN4] && pin_prev_reg[`POL_PIN4]
         && !pin_now[`POL_PIN4]
      |=> flags_first_reg[`POL_PIN4];
   endproperty
   a_pin4_falling: assert property (p_pin4_falling) // RL2
      else $error("Pin 4 falling edge did not set its flag.");

   property p_timer_f_falling;
      ce_in && !edge_polarity_reg[`POL_PIN3] && pin_prev_reg[`LANE_TIMER_F]
         && !pins_in.timer_f_event_input
      |=> edge_pulses_out.timer_f_event;
   endproperty
   a_timer_f_falling: assert property (p_timer_f_falling) // RL3
      else $error("Falling timer F edge was not reported.");

   property p_timer_c_rising;
      ce_in && edge_polarity_reg[`POL_PIN1] && !pin_prev_reg[`LANE_TIMER_C]
         && pins_in.timer_c_event_input
      |=> edge_pulses_out.timer_c_event;
   endproperty
   a_timer_c_rising: assert property (p_timer_c_rising) // RL5
      else $error("Rising timer C edge was not reported.");

   property p_wakeup_gate;
      ce_in && !global_mask_in && wakeup_request_in && enable_first_reg[`BIT_WAKEUP]
      |=> pending_first_out[`BIT_WAKEUP];
   endproperty
   a_wakeup_gate: assert property (p_wakeup_gate) // RL9
      else $error("Enabled wakeup group gave no pending request.");

   property p_pin_gates;
      ce_in |=> (pending_first_out[4:0] & ~$past(enable_first_reg[4:0])) == 5'h00;
   endproperty
   a_pin_gates: assert property (p_pin_gates) // RL10
      else $error("Disabled external pin showed a pending request.");

   property p_direct_gate;
      ce_in && !global_mask_in && flags_second_reg[`BIT_DIRECT]
         && enable_second_reg[`BIT_DIRECT]
      |=> pending_second_out[`BIT_DIRECT];
   endproperty
   a_direct_gate: assert property (p_direct_gate) // RL11
      else $error("Enabled direct transfer flag gave no request.");

   property p_second_spare_storage;
      ce_in && wr_en2 |=> enable_second_reg[`BIT_SPARE_SECOND] == $past(wdata_in[5]);
   endproperty
   a_second_spare_storage: assert property (p_second_spare_storage) // RL13
      else $error("Spare second enable bit did not store the written value.");

   property p_timer_g_gate;
      ce_in && !global_mask_in && flags_second_reg[`BIT_TIMER_G]
         && enable_second_reg[`BIT_TIMER_G]
      |=> pending_second_out[`BIT_TIMER_G];
   endproperty
   a_timer_g_gate: assert property (p_timer_g_gate) // RL14
      else $error("Enabled timer G flag gave no request.");

   property p_second_gates;
      ce_in |=> (pending_second_out & ~$past(enable_second_reg)) == 8'h00;
   endproperty
   a_second_gates: assert property (p_second_gates) // RL16
      else $error("Disabled second source showed a pending request.");

   property p_event_counter_gate;
      ce_in && !global_mask_in && flags_second_reg[`BIT_EVENT_CNT]
         && enable_second_reg[`BIT_EVENT_CNT]
      |=> pending_second_out[`BIT_EVENT_CNT];
   endproperty
   a_event_counter_gate: assert property (p_event_counter_gate) // RL18
      else $error("Enabled event counter flag gave no request.");

   c_masked_then_unmasked: cover property (global_mask_in ##1 !global_mask_in ##1 irq_request_out);
   c_flag_cleared: cover property (flags_first_reg[0] && wr_flag1 && !wdata_in[0]);
   c_set_beats_clear: cover property (wr_flag2 && !wdata_in[1] && events_in.timer_c);
   c_wakeup_pending: cover property (pending_first_out[`BIT_WAKEUP]);
   c_trigger_rising: cover property (edge_pulses_out.conversion_trigger && edge_polarity_reg[`POL_PIN4]);

endmodule

/* File: rtl/intc_defines.svh */
// Register addresses, field positions and reset values of the interrupt control block.
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

`define ADDR_EDGE_POLARITY  16'hFFF2
`define ADDR_ENABLE_FIRST   16'hFFF3
`define ADDR_ENABLE_SECOND  16'hFFF4
`define ADDR_FLAGS_FIRST    16'hFFF6
`define ADDR_FLAGS_SECOND   16'hFFF7

`define EDGE_FIXED_ONES     3'h7
`define EDGE_POL_RESET      5'h00
`define ENABLE_RESET        8'h00
`define FLAGS_RESET         8'h00
`define FLAGS_FIRST_FIXED   8'h20
`define FLAGS_SECOND_SPARE  8'h20
`define PIN_IDLE            8'hFF
`define PEND_FIRST_MASK     8'hBF
`define PEND_SECOND_MASK    8'hDF
`define RDATA_IDLE          8'h00
`define BYTE_ZERO           8'h00

`define POL_PIN4            4
`define POL_PIN3            3
`define POL_PIN2            2
`define POL_PIN1            1
`define POL_PIN0            0

`define BIT_TIMER_A         7
`define BIT_SPARE_FIRST     6
`define BIT_WAKEUP          5
`define BIT_DIRECT          7
`define BIT_CONV_END        6
`define BIT_SPARE_SECOND    5
`define BIT_TIMER_G         4
`define BIT_TIMER_FH        3
`define BIT_TIMER_FL        2
`define BIT_TIMER_C         1
`define BIT_EVENT_CNT       0

`define LANE_TRIGGER        5
`define LANE_TIMER_F        6
`define LANE_TIMER_C        7

`endif

/* File: rtl/intc_pkg.sv */
// Types shared by the interrupt edge and enable control block.
package intc_pkg;

   typedef struct packed {
      logic       timer_c_event_input;
      logic       timer_f_event_input;
      logic       conversion_trigger_pin;
      logic [4:0] external_pin;
   } pins_s;

   typedef struct packed {
      logic timer_c_event;
      logic timer_f_event;
      logic conversion_trigger;
   } edge_pulses_s;

   typedef struct packed {
      logic timer_a_overflow;
      logic direct_transfer;
      logic conversion_end;
      logic timer_g;
      logic timer_f_high;
      logic timer_f_low;
      logic timer_c;
      logic event_counter;
   } source_events_s;

endpackage

/* File: test/source_model.sv */
// Behavioural model of the pins and interrupt sources that feed the controller.
`timescale 1ns/1ps
module source_model (
   input  wire logic                     clk_in,
   output intc_pkg::source_events_s      events_out,
   output intc_pkg::pins_s               pins_out
);
   import intc_pkg::*;

   // Pins idle high, so the first falling edge is a real transition.
   initial begin
      events_out = '0;
      pins_out = '1;
   end

   task automatic pulse(input logic [7:0] m);
      @(posedge clk_in);
      events_out <= m;
      @(posedge clk_in);
      events_out <= '0;
   endtask

   task automatic set_pins(input logic [7:0] v);
      @(posedge clk_in);
      pins_out <= v;
   endtask
endmodule

/* File: test/tb_interrupt_edge_and_enable_regs.sv */
// Self-checking bench for the interrupt edge polarity and enable registers.
`timescale 1ns/1ps
`include "intc_defines.svh"
module tb_interrupt_edge_and_enable_regs;
   import intc_pkg::*;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rexp;
   } row_s;

   logic           clk_in            = 1'b0;
   logic           rst_in            = 1'b1;
   logic           ce_in             = 1'b1;
   logic [15:0]    addr_in           = 16'h0000;
   logic [7:0]     wdata_in          = 8'h00;
   logic           wr_in             = 1'b0;
   logic           rd_in             = 1'b0;
   logic           wakeup_request_in = 1'b0;
   logic           global_mask_in    = 1'b0;
   logic [7:0]     rdata_out;
   logic [7:0]     pending_first_out;
   logic [7:0]     pending_second_out;
   logic           irq_request_out;
   pins_s          pins;
   source_events_s events;
   edge_pulses_s   edge_pulses_out;
   logic [2:0]     seen              = 3'h0;
   logic [7:0]     rd_val;
   int             mismatches        = 0;
   int             tests_run         = 0;

   row_s resets [6] = '{'{`ADDR_EDGE_POLARITY, 8'h00, 8'hE0},
      '{`ADDR_ENABLE_FIRST, 8'h00, 8'h00}, '{`ADDR_ENABLE_SECOND, 8'h00, 8'h00},
      '{`ADDR_FLAGS_FIRST, 8'h00, 8'h20}, '{`ADDR_FLAGS_SECOND, 8'h00, 8'h00},
      '{16'hFFF5, 8'h00, 8'h00}};
   row_s rows [10] = '{'{`ADDR_EDGE_POLARITY, 8'hFF, 8'hFF},
      '{`ADDR_EDGE_POLARITY, 8'h00, 8'hE0}, '{`ADDR_ENABLE_FIRST, 8'hA5, 8'hA5},
      '{`ADDR_ENABLE_FIRST, 8'h5A, 8'h5A}, '{`ADDR_ENABLE_SECOND, 8'hA5, 8'hA5},
      '{`ADDR_ENABLE_SECOND, 8'h5A, 8'h5A}, '{16'hFFF5, 8'hFF, 8'h00},
      '{`ADDR_FLAGS_SECOND, 8'hFF, 8'h20}, '{`ADDR_FLAGS_SECOND, 8'h00, 8'h00},
      '{`ADDR_ENABLE_FIRST, 8'h1F, 8'h1F}};

   interrupt_edge_and_enable_regs u_interrupt_edge_and_enable_regs (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .pins_in(pins), .events_in(events), .wakeup_request_in(wakeup_request_in),
      .global_mask_in(global_mask_in), .edge_pulses_out(edge_pulses_out),
      .pending_first_out(pending_first_out), .pending_second_out(pending_second_out),
      .irq_request_out(irq_request_out));

   source_model u_source_model (.clk_in(clk_in), .events_out(events), .pins_out(pins));

   always #2.5 clk_in = ~clk_in;

   // Edge pulses last one cycle, so they are gathered into a sticky record.
   always @(posedge clk_in) begin
      seen <= seen | edge_pulses_out;
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask

   task automatic settle();
      repeat (3) @(posedge clk_in);
      #1;
   endtask

   task automatic check_resets();
      foreach (resets[i]) begin
         bus_read(resets[i].addr, rd_val);
         chk("reset value", resets[i].rexp, rd_val);
      end
   endtask

   task automatic edge_case(input int n);
      logic [7:0] pin_bits;
      logic [2:0] lane;
      lane = (n == 4) ? 3'h1 : (n == 3) ? 3'h2 : (n == 1) ? 3'h4 : 3'h0;
      pin_bits = (8'h01 << n) | {lane, 5'h00};
      seen = 3'h0;
      u_source_model.set_pins(~pin_bits);
      settle();
      chk("pending on fall", 8'h01 << n, pending_first_out);
      chk("pulse on fall", {5'h00, lane}, {5'h00, seen});
      bus_write(`ADDR_FLAGS_FIRST, 8'h00);
      bus_write(`ADDR_EDGE_POLARITY, 8'h01 << n);
      seen = 3'h0;
      u_source_model.set_pins(8'hFF);
      settle();
      chk("pending on rise", 8'h01 << n, pending_first_out);
      chk("pulse on rise", {5'h00, lane}, {5'h00, seen});
      bus_write(`ADDR_FLAGS_FIRST, 8'h00);
      seen = 3'h0;
      u_source_model.set_pins(~pin_bits);
      settle();
      chk("opposite edge", 8'h00, pending_first_out);
      chk("opposite pulse", 8'h00, {5'h00, seen});
      bus_write(`ADDR_EDGE_POLARITY, 8'h00);
      u_source_model.set_pins(8'hFF);
      settle();
      bus_write(`ADDR_FLAGS_FIRST, 8'h00);
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // The whole sequence needs about 300 cycles; the 10000 cycle limit leaves ample margin.
   initial begin
      #50000;
      mismatches++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      check_resets();
      foreach (rows[i]) begin
         bus_write(rows[i].addr, rows[i].wdata);
         bus_read(rows[i].addr, rd_val);
         chk("readback", rows[i].rexp, rd_val);
      end
      for (int n = 0; n < 5; n++) begin
         edge_case(n);
      end
      bus_write(`ADDR_ENABLE_FIRST, 8'h00);
      bus_write(`ADDR_ENABLE_SECOND, 8'h00);
      u_source_model.pulse(8'hFF);
      settle();
      chk("gated irq", 8'h00, {7'h00, irq_request_out});
      bus_read(`ADDR_FLAGS_SECOND, rd_val);
      chk("flags second", 8'hDF, rd_val);
      for (int k = 0; k < 8; k++) begin
         bus_write(`ADDR_ENABLE_SECOND, 8'h01 << k);
         settle();
         chk("pending second", (8'h01 << k) & 8'hDF, pending_second_out);
         chk("irq second", {7'h00, k != 5}, {7'h00, irq_request_out});
      end
      bus_write(`ADDR_ENABLE_SECOND, 8'h00);
      bus_write(`ADDR_ENABLE_FIRST, 8'hA0);
      wakeup_request_in <= 1'b1;
      settle();
      chk("pending first", 8'hA0, pending_first_out);
      @(posedge clk_in) global_mask_in <= 1'b1;
      settle();
      chk("masked pending", 8'h00, pending_first_out);
      chk("masked irq", 8'h00, {7'h00, irq_request_out});
      bus_read(`ADDR_FLAGS_FIRST, rd_val);
      chk("flags kept", 8'hA0, rd_val);
      @(posedge clk_in);
      global_mask_in <= 1'b0;
      wakeup_request_in <= 1'b0;
      bus_write(`ADDR_FLAGS_FIRST, 8'hFF);
      settle();
      chk("write one keeps", 8'h80, pending_first_out);
      bus_write(`ADDR_FLAGS_FIRST, 8'h00);
      settle();
      chk("write zero clears", 8'h00, pending_first_out);
      @(posedge clk_in) ce_in <= 1'b0;
      bus_write(`ADDR_ENABLE_FIRST, 8'hFF);
      @(posedge clk_in) ce_in <= 1'b1;
      bus_read(`ADDR_ENABLE_FIRST, rd_val);
      chk("frozen write", 8'hA0, rd_val);
      @(posedge clk_in) rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      check_resets();
      stop_test();
   end
endmodule
